// ==== logic/ipm_bank.sv ====
// Interrupt pending and mask bank with AXI4-Lite register slave
//
// Behaviour
// RL1: Pin group A enable bits mask their pin at 0 (reset) and pass at 1.
// RL2: Pin group A polarity 0 (reset) senses falling/low, 1 rising/high.
// RL3: A qualifying event on pin group B pin n sets pending bit n.
// RL4: Writing 1 clears a group B pending bit; writing 0 leaves it.
// RL5: Every group B source is maskable by its own enable bit.
// RL6: Group B enable bit n masks pin n at 0 (reset) and passes it at 1.
// RL7: Group B polarity bit n senses falling/low at 0, rising/high at 1.
// RL8: Edge/level select with polarity gives four sensing modes per pin.
// RL9: System sources 15 to 8 are clock, discard-timer and protocol errors.
// RL10: System sources 7 to 0 are bus-master, buffer and overflow errors.
// RL11: System pending bits latch internal errors and clear at reset.
// RL12: Low system byte holds sources 7 to 0, high byte 15 to 8.
// RL13: Writing 1 clears only that system pending bit; 0 keeps it.
// RL14: System enable bits mask at 0 (reset) and pass at 1, both bytes.
// RL15: Pin group A pending bits latch pin events and clear on write 1.
// RL16: With the controller off, the error output is the OR of system bits.
// RL17: Only enabled pending bits raise the interrupt; masked ones latch.
`timescale 1ns/100ps
module ipm_bank
    import ipm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  pinGroupA,
    input  wire logic [7:0]  pinGroupB,
    input  wire logic        clkFailsafe,
    input  wire logic        clkFallback,
    input  wire logic        mbDiscardExpired,
    input  wire logic        vcDiscardExpired,
    input  wire logic        dmDiscardExpired,
    input  wire logic        mbProtocolErr,
    input  wire logic        vcProtocolErr,
    input  wire logic        dmProtocolErr,
    input  wire logic        busFatalErr,
    input  wire logic        bufLockErr,
    input  wire logic        stallErr,
    input  wire logic        stallWarn,
    input  wire logic        overwriteWarn,
    input  wire logic        initialWarn,
    input  wire logic        scratchOvfWarn,
    input  wire logic        notifyQueueOvfWarn,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irqOut,
    output logic             systemErrorOutput
);

    typedef struct packed {
        logic [15:0] pinSync1;
        logic [15:0] pinSync2;
        logic [15:0] pinPrev;
        logic [7:0]  pendA;
        logic [7:0]  maskA;
        logic [7:0]  senseA;
        logic [7:0]  edgeA;
        logic [7:0]  pendB;
        logic [7:0]  maskB;
        logic [7:0]  senseB;
        logic [7:0]  edgeB;
        logic [15:0] sysPend;
        logic [15:0] sysMask;
        logic        ctrlEn;
        logic        awHave;
        logic [13:0] awIdx;
        logic        wHave;
        logic [7:0]  wByte;
        logic        wLane0;
        logic        awRdy;
        logic        wRdy;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arRdy;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        irq;
        logic        system_error_output;
    } ipm_state_s;

    ipm_state_s stateQ;
    ipm_state_s stateD;
    logic [15:0] sysSrc;

    // System source wiring, one bit per internal error
    // Sources already run on this clock, so no synchroniser
    // RL9: upper source order
    assign sysSrc[SYS_CLK_FAILSAFE]   = clkFailsafe;
    assign sysSrc[SYS_CLK_FALLBACK]   = clkFallback;
    assign sysSrc[SYS_MB_DISCARD]     = mbDiscardExpired;
    assign sysSrc[SYS_VC_DISCARD]     = vcDiscardExpired;
    assign sysSrc[SYS_DM_DISCARD]     = dmDiscardExpired;
    assign sysSrc[SYS_MB_PROTO]       = mbProtocolErr;
    assign sysSrc[SYS_VC_PROTO]       = vcProtocolErr;
    assign sysSrc[SYS_DM_PROTO]       = dmProtocolErr;
    // RL10: lower source order
    assign sysSrc[SYS_BUS_FATAL]      = busFatalErr;
    assign sysSrc[SYS_BUF_LOCK]       = bufLockErr;
    assign sysSrc[SYS_STALL_ERR]      = stallErr;
    assign sysSrc[SYS_STALL_WARN]     = stallWarn;
    assign sysSrc[SYS_OVERWRITE_WARN] = overwriteWarn;
    assign sysSrc[SYS_INITIAL_WARN]   = initialWarn;
    assign sysSrc[SYS_SCRATCH_OVF]    = scratchOvfWarn;
    assign sysSrc[SYS_NOTIFY_OVF]     = notifyQueueOvfWarn;

    // Next-state logic for pins, registers and bus
    always_comb
    begin
        logic [15:0] pol;
        logic [15:0] lvl;
        logic [15:0] hit;
        logic [7:0]  clrA;
        logic [7:0]  clrB;
        logic [15:0] clrSys;
        logic        doWrite;
        logic [7:0]  wb;
        logic [13:0] ri;
        // Scratch values start at zero on every pass
        pol     = 16'h0000;
        lvl     = 16'h0000;
        hit     = 16'h0000;
        clrA    = 8'h00;
        clrB    = 8'h00;
        clrSys  = 16'h0000;
        doWrite = 1'b0;
        wb      = 8'h00;
        ri      = 14'h0000;
        stateD  = stateQ;

        // Two-stage synchroniser, then a history stage for edges
        // Only the second stage reads the first
        stateD.pinSync1 = {pinGroupB, pinGroupA};
        stateD.pinSync2 = stateQ.pinSync1;
        stateD.pinPrev  = stateQ.pinSync2;

        // RL2: group A polarity
        // RL7: group B polarity
        pol = {stateQ.senseB, stateQ.senseA};
        lvl = {stateQ.edgeB, stateQ.edgeA};
        // RL8: four sense modes
        for (int i = 0; i < 16; i++)
        begin
            // Level mode fires while the pin sits at its active level,
            // edge mode only in the cycle it first gets there
            if (lvl[i])
                hit[i] = (stateQ.pinSync2[i] == pol[i]);
            else
                hit[i] = (stateQ.pinSync2[i] == pol[i])
                         && (stateQ.pinPrev[i] != pol[i]);
        end

        // Capture write address and data independently
        // Each ready stays low until the write answer is taken
        if (s_axi_awvalid && stateQ.awRdy)
        begin
            stateD.awHave = 1'b1;
            stateD.awIdx  = s_axi_awaddr[15:2];
            stateD.awRdy  = 1'b0;
        end
        if (s_axi_wvalid && stateQ.wRdy)
        begin
            stateD.wHave  = 1'b1;
            stateD.wByte  = s_axi_wdata[7:0];
            stateD.wLane0 = s_axi_wstrb[0];
            stateD.wRdy   = 1'b0;
        end

        // Perform the write once both halves are held
        if (stateQ.awHave && stateQ.wHave && !stateQ.bValid)
        begin
            doWrite       = stateQ.wLane0;
            wb            = stateQ.wByte;
            stateD.bValid = 1'b1;
            stateD.bResp  = RESP_OKAY;
            if (stateQ.awIdx == IDX_A_PENDING)
                clrA = doWrite ? wb : 8'h00;
            else if (stateQ.awIdx == IDX_A_MASK)
            begin
                if (doWrite)
                    stateD.maskA = wb;
            end
            else if (stateQ.awIdx == IDX_A_SENSE)
            begin
                if (doWrite)
                    stateD.senseA = wb;
            end
            else if (stateQ.awIdx == IDX_B_PENDING)
                clrB = doWrite ? wb : 8'h00;
            else if (stateQ.awIdx == IDX_B_MASK)
            begin
                if (doWrite)
                    stateD.maskB = wb;
            end
            else if (stateQ.awIdx == IDX_B_SENSE)
            begin
                if (doWrite)
                    stateD.senseB = wb;
            end
            else if (stateQ.awIdx == IDX_SYS_PEND_LO)
                clrSys[7:0] = doWrite ? wb : 8'h00;
            else if (stateQ.awIdx == IDX_SYS_PEND_HI)
                clrSys[15:8] = doWrite ? wb : 8'h00;
            else if (stateQ.awIdx == IDX_SYS_MASK_LO)
            begin
                if (doWrite)
                    stateD.sysMask[7:0] = wb;
            end
            else if (stateQ.awIdx == IDX_SYS_MASK_HI)
            begin
                if (doWrite)
                    stateD.sysMask[15:8] = wb;
            end
            else if (stateQ.awIdx == IDX_A_EDGE)
            begin
                if (doWrite)
                    stateD.edgeA = wb;
            end
            else if (stateQ.awIdx == IDX_B_EDGE)
            begin
                if (doWrite)
                    stateD.edgeB = wb;
            end
            else if (stateQ.awIdx == IDX_CTRL)
            begin
                if (doWrite)
                    stateD.ctrlEn = wb[CTRL_EN_BIT];
            end
            // Unmapped index is refused and changes nothing
            else
                stateD.bResp = RESP_SLVERR;
        end

        // Release the write channels when the response is taken
        if (stateQ.bValid && s_axi_bready)
        begin
            stateD.bValid = 1'b0;
            stateD.awHave = 1'b0;
            stateD.wHave  = 1'b0;
            stateD.awRdy  = 1'b1;
            stateD.wRdy   = 1'b1;
        end

        // Pending updates: a new event wins over a same-cycle clear
        // so an event that lands during a clear is never lost
        // RL15: group A latch and clear
        stateD.pendA = (stateQ.pendA & ~clrA) | hit[7:0];
        // RL3: group B latch
        // RL4: group B write one clears
        stateD.pendB = (stateQ.pendB & ~clrB) | hit[15:8];
        // RL11: system latch
        // RL13: system write one clears
        stateD.sysPend = (stateQ.sysPend & ~clrSys) | sysSrc;

        // Read channel, one outstanding read
        // Data is registered and stands until rready
        if (s_axi_arvalid && stateQ.arRdy)
        begin
            ri           = s_axi_araddr[15:2];
            stateD.arRdy  = 1'b0;
            stateD.rValid = 1'b1;
            stateD.rResp  = RESP_OKAY;
            stateD.rData  = 32'h0000_0000;
            if (ri == IDX_A_PENDING)
                stateD.rData[7:0] = stateQ.pendA;
            else if (ri == IDX_A_MASK)
                stateD.rData[7:0] = stateQ.maskA;
            else if (ri == IDX_A_SENSE)
                stateD.rData[7:0] = stateQ.senseA;
            else if (ri == IDX_B_PENDING)
                stateD.rData[7:0] = stateQ.pendB;
            else if (ri == IDX_B_MASK)
                stateD.rData[7:0] = stateQ.maskB;
            else if (ri == IDX_B_SENSE)
                stateD.rData[7:0] = stateQ.senseB;
            // RL12: byte placement
            else if (ri == IDX_SYS_PEND_LO)
                stateD.rData[7:0] = stateQ.sysPend[7:0];
            else if (ri == IDX_SYS_PEND_HI)
                stateD.rData[7:0] = stateQ.sysPend[15:8];
            else if (ri == IDX_SYS_MASK_LO)
                stateD.rData[7:0] = stateQ.sysMask[7:0];
            else if (ri == IDX_SYS_MASK_HI)
                stateD.rData[7:0] = stateQ.sysMask[15:8];
            else if (ri == IDX_A_EDGE)
                stateD.rData[7:0] = stateQ.edgeA;
            else if (ri == IDX_B_EDGE)
                stateD.rData[7:0] = stateQ.edgeB;
            else if (ri == IDX_CTRL)
                stateD.rData[CTRL_EN_BIT] = stateQ.ctrlEn;
            // Unmapped index reads zero and is refused
            else
                stateD.rResp = RESP_SLVERR;
        end
        if (stateQ.rValid && s_axi_rready)
        begin
            stateD.rValid = 1'b0;
            stateD.arRdy  = 1'b1;
        end

        // Interrupt and error outputs from the new pending state
        // Pins count only while the controller is on
        // RL1: group A mask
        // RL5: group B maskable
        // RL6: group B mask
        // RL14: system mask
        // RL17: masked bits still latch
        stateD.irq = (|(stateD.sysPend & stateD.sysMask))
                     | (stateD.ctrlEn
                        & ((|(stateD.pendA & stateD.maskA))
                           | (|(stateD.pendB & stateD.maskB))));
        // RL16: plain OR when off
        if (stateD.ctrlEn)
            stateD.system_error_output = |(stateD.sysPend & stateD.sysMask);
        else
            stateD.system_error_output = |stateD.sysPend;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stateQ          <= '0;
            stateQ.maskA    <= RST_BYTE;
            stateQ.senseA   <= RST_BYTE;
            stateQ.edgeA    <= RST_BYTE;
            stateQ.maskB    <= RST_BYTE;
            stateQ.senseB   <= RST_BYTE;
            stateQ.edgeB    <= RST_BYTE;
            stateQ.pendA    <= RST_BYTE;
            stateQ.pendB    <= RST_BYTE;
            stateQ.sysPend  <= RST_SYS;
            stateQ.sysMask  <= RST_SYS;
            stateQ.ctrlEn   <= RST_CTRL_EN;
            // Channels leave reset ready for a request
            stateQ.awRdy    <= 1'b1;
            stateQ.wRdy     <= 1'b1;
            stateQ.arRdy    <= 1'b1;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready     = stateQ.awRdy;
    assign s_axi_wready      = stateQ.wRdy;
    assign s_axi_bvalid      = stateQ.bValid;
    assign s_axi_bresp       = stateQ.bResp;
    assign s_axi_arready     = stateQ.arRdy;
    assign s_axi_rvalid      = stateQ.rValid;
    assign s_axi_rdata       = stateQ.rData;
    assign s_axi_rresp       = stateQ.rResp;
    assign irqOut            = stateQ.irq;
    assign systemErrorOutput = stateQ.system_error_output;

endmodule

// ==== inc/ipm_pkg.sv ====
// Register map, field layout and bus constants for the interrupt bank
package ipm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_A_PENDING   = 14'h0600;
    localparam logic [13:0] IDX_A_MASK      = 14'h0601;
    localparam logic [13:0] IDX_A_SENSE     = 14'h0603;
    localparam logic [13:0] IDX_B_PENDING   = 14'h0604;
    localparam logic [13:0] IDX_B_MASK      = 14'h0605;
    localparam logic [13:0] IDX_B_SENSE     = 14'h0607;
    localparam logic [13:0] IDX_SYS_PEND_LO = 14'h0608;
    localparam logic [13:0] IDX_SYS_PEND_HI = 14'h0609;
    localparam logic [13:0] IDX_SYS_MASK_LO = 14'h060a;
    localparam logic [13:0] IDX_SYS_MASK_HI = 14'h060b;
    localparam logic [13:0] IDX_A_EDGE      = 14'h0620;
    localparam logic [13:0] IDX_B_EDGE      = 14'h0621;
    localparam logic [13:0] IDX_CTRL        = 14'h0622;

    // Reset values
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [15:0] RST_SYS         = 16'h0000;
    localparam logic        RST_CTRL_EN     = 1'b0;

    // Control register: bit 0 enables the interrupt controller
    localparam int          CTRL_EN_BIT     = 0;

    // System source bit positions
    localparam int SYS_CLK_FAILSAFE   = 15;
    localparam int SYS_CLK_FALLBACK   = 14;
    localparam int SYS_MB_DISCARD     = 13;
    localparam int SYS_VC_DISCARD     = 12;
    localparam int SYS_DM_DISCARD     = 11;
    localparam int SYS_MB_PROTO       = 10;
    localparam int SYS_VC_PROTO       = 9;
    localparam int SYS_DM_PROTO       = 8;
    localparam int SYS_BUS_FATAL      = 7;
    localparam int SYS_BUF_LOCK       = 6;
    localparam int SYS_STALL_ERR      = 5;
    localparam int SYS_STALL_WARN     = 4;
    localparam int SYS_OVERWRITE_WARN = 3;
    localparam int SYS_INITIAL_WARN   = 2;
    localparam int SYS_SCRATCH_OVF    = 1;
    localparam int SYS_NOTIFY_OVF     = 0;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// ==== verif/ipm_pin_dev.sv ====
// Behavioural model of the devices that drive both interrupt pin groups
`timescale 1ns/100ps
module ipm_pin_dev (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [7:0] newA,
    input  wire logic [7:0] newB,
    output logic      [7:0] pinA,
    output logic      [7:0] pinB
);
    logic [7:0] holdA;
    logic [7:0] holdB;
    logic [2:0] cnt;

    // Take a pattern and drive it one or four cycles later
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pinA <= 8'h00;
            pinB <= 8'h00;
            cnt  <= 3'h0;
        end
        else if (go)
        begin
            holdA <= newA;
            holdB <= newB;
            cnt   <= slow ? 3'h4 : 3'h1;
        end
        else if (cnt != 3'h0)
        begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1)
            begin
                pinA <= holdA;
                pinB <= holdB;
            end
        end
    end
endmodule

// ==== verif/ipm_bank_chk.sv ====
// Checker of bus handshakes and interrupt outputs of the bank
`timescale 1ns/100ps
module ipm_bank_chk
    import ipm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irqOut,
    input wire logic        systemErrorOutput
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles since write data was last taken, saturating
    logic [2:0] wAge_q;
    always_ff @(posedge clk)
        if (rst || (s_axi_wvalid && s_axi_wready))
            wAge_q <= 3'h0;
        else if (wAge_q != 3'h7)
            wAge_q <= wAge_q + 3'h1;

    // Write address and data taken together, then the answer
    sequence wrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wrAnswer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    rst_quiet_a: assert property (disable iff (1'b0) rst |=>
        !irqOut && !systemErrorOutput && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
    wr_latency_a: assert property (wrBoth |=> wrAnswer)
        else $error("write answer late or early");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    wr_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer open");
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("refused read returns data");
    irq_sticky_a: assert property ($fell(irqOut)
        |-> wAge_q <= 3'h4)
        else $error("interrupt fell without a write");
    err_sticky_a: assert property ($fell(systemErrorOutput)
        |-> wAge_q <= 3'h4)
        else $error("error output fell without a write");
endmodule

bind ipm_bank ipm_bank_chk i_ipm_bank_chk (
    .clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irqOut(irqOut),
    .systemErrorOutput(systemErrorOutput));

// ==== verif/ipm_bank_tb.sv ====
// Self-checking bench for the interrupt pending and mask bank
`timescale 1ns/100ps
module ipm_bank_tb
    import ipm_pkg::*;
;
    localparam logic [13:0] REGS [10] = '{IDX_A_MASK, IDX_A_SENSE,
        IDX_B_MASK, IDX_B_SENSE, IDX_SYS_MASK_LO, IDX_SYS_MASK_HI,
        IDX_A_PENDING, IDX_B_PENDING, IDX_SYS_PEND_LO, IDX_SYS_PEND_HI};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] sysV = 16'h0;
    logic [15:0] awaddr = 16'h0;
    logic [15:0] araddr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0;
    logic        arv = 1'b0, rready = 1'b0, pgo = 1'b0, pslow = 1'b0;
    logic [7:0]  pnA = 8'h0, pnB = 8'h0, pinA, pinB, b, mk;
    logic        awready, wready, bvalid, arready, rvalid, irqOut, system_error_output;
    logic [1:0]  bresp, rresp, lastResp;
    logic [31:0] rdata, rdVal, v;
    logic [31:0] seed = 32'h8e85;
    logic [13:0] pl;
    int          nFail = 0;
    int          samplesChecked = 0;

    always #12.5 clk = ~clk;

    ipm_bank i_ipm_bank (.clk(clk), .rst(rst), .pinGroupA(pinA),
        .pinGroupB(pinB), .clkFailsafe(sysV[15]), .clkFallback(sysV[14]),
        .mbDiscardExpired(sysV[13]), .vcDiscardExpired(sysV[12]),
        .dmDiscardExpired(sysV[11]), .mbProtocolErr(sysV[10]),
        .vcProtocolErr(sysV[9]), .dmProtocolErr(sysV[8]),
        .busFatalErr(sysV[7]), .bufLockErr(sysV[6]), .stallErr(sysV[5]),
        .stallWarn(sysV[4]), .overwriteWarn(sysV[3]),
        .initialWarn(sysV[2]), .scratchOvfWarn(sysV[1]),
        .notifyQueueOvfWarn(sysV[0]), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irqOut(irqOut),
        .systemErrorOutput(system_error_output));

    ipm_pin_dev i_ipm_pin_dev (.clk(clk), .rst(rst), .go(pgo),
        .slow(pslow), .newA(pnA), .newB(pnB), .pinA(pinA), .pinB(pinB));

    // Repeatable random source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected byte of a system source vector
    function automatic logic [7:0] byteOf(input logic [15:0] s, input bit h);
        return h ? s[15:8] : s[7:0];
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chkD(input string s, input logic [31:0] e, g);
        samplesChecked++;
        if (g !== e)
        begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic chkF(input string s, input logic e, g);
        chkD(s, {31'h0, e}, {31'h0, g});
    endtask

    task automatic stall(input int t);
        if (t >= 40)
        begin
            chkD("bus answer", 32'h0, 32'(t));
            close_out();
        end
    endtask

    // Bus write: address and data offered together, held until taken
    task automatic axWr(input logic [13:0] idx, input logic [7:0] d);
        int t;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end
        while (!bvalid && t < 40);
        bready <= 1'b0;
        lastResp = bresp;
        stall(t);
    endtask

    // Bus read: address held until taken, data taken with rvalid
    task automatic axRd(input logic [13:0] idx);
        int t;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arv <= 1'b1;
        rready <= 1'b1;
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
            if (arready) arv <= 1'b0;
        end
        while (!rvalid && t < 40);
        rready <= 1'b0;
        rdVal = rdata;
        lastResp = rresp;
        stall(t);
    endtask

    // Hand a new pin pattern to the pin model and let it settle
    task automatic pinSet(input bit g, input logic [7:0] p, input bit s);
        @(posedge clk);
        if (g) pnA <= p; else pnB <= p;
        pgo <= 1'b1;
        pslow <= s;
        @(posedge clk);
        pgo <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // One pin in one of the four sensing modes
    task automatic pinCase(input bit g, input logic [2:0] n, input bit lvl,
                           input bit pol);
        logic [13:0] pb;
        logic [7:0]  e;
        pb = g ? IDX_A_PENDING : IDX_B_PENDING;
        e = 8'h01 << n;
        axWr(pb + 14'h1, e);
        axWr(pb + 14'h3, pol ? e : 8'h00);
        axWr(g ? IDX_A_EDGE : IDX_B_EDGE, lvl ? e : 8'h00);
        pinSet(g, pol ? 8'h00 : e, n[0]);
        axWr(pb, 8'hff);
        axRd(pb);
        chkD("pin idle", 32'h0, rdVal);
        pinSet(g, pol ? e : 8'h00, !n[0]);
        axRd(pb);
        chkD("pin set", {24'h0, e}, rdVal);
        chkF("pin irq", 1'b1, irqOut);
        axWr(pb, ~e);
        axRd(pb);
        chkD("pin keep", {24'h0, e}, rdVal);
        axWr(pb, e);
        axRd(pb);
        chkD("pin clear", lvl ? {24'h0, e} : 32'h0, rdVal);
        chkF("pin irq clear", lvl, irqOut);
        axWr(pb + 14'h1, 8'h00);
        pinSet(g, 8'h00, 1'b0);
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (REGS[i])
        begin
            axRd(REGS[i]);
            chkD("reset value", 32'h0, rdVal);
        end
        for (int i = 0; i < 6; i++)
        begin
            v = xs();
            axWr(REGS[i], v[7:0]);
            axRd(REGS[i]);
            chkD("readback", {24'h0, v[7:0]}, rdVal);
            axWr(REGS[i], 8'h00);
        end
        axWr(14'h0602, 8'hff);
        chkD("unmapped write", 32'(RESP_SLVERR), 32'(lastResp));
        axRd(14'h0602);
        chkD("unmapped read", 32'(RESP_SLVERR), 32'(lastResp));
        $display("test registers done");
        for (int i = 0; i < 16; i++)
        begin
            b = 8'h01 << i[2:0];
            pl = IDX_SYS_PEND_LO + 14'(i[3]);
            mk = xs() % 2 ? b : 8'h00;
            axWr(IDX_SYS_MASK_LO + 14'(i[3]), mk);
            @(posedge clk);
            sysV <= 16'h1 << i;
            @(posedge clk);
            sysV <= 16'h0;
            for (int h = 0; h < 2; h++)
            begin
                axRd(IDX_SYS_PEND_LO + 14'(h));
                v = {24'h0, byteOf(16'h1 << i, h[0])};
                chkD("sys pend", v, rdVal);
            end
            chkF("sys out", 1'b1, system_error_output);
            chkF("sys irq", mk != 8'h0, irqOut);
            axWr(pl, ~b);
            axRd(pl);
            chkD("sys keep", {24'h0, b}, rdVal);
            axWr(pl, b);
            axRd(pl);
            chkD("sys clear", 32'h0, rdVal);
            chkF("sys out clear", 1'b0, system_error_output);
            axWr(IDX_SYS_MASK_LO + 14'(i[3]), 8'h00);
        end
        $display("test system sources done");
        axWr(IDX_CTRL, 8'h01);
        for (int g = 0; g < 2; g++)
            for (int m = 0; m < 4; m++)
                pinCase(g[0], 3'(xs()), m[1], m[0]);
        $display("test pins done");
        @(posedge clk);
        sysV <= 16'h8001;
        @(posedge clk);
        sysV <= 16'h0;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        axRd(IDX_SYS_PEND_HI);
        chkD("pend after reset", 32'h0, rdVal);
        $display("test second reset done");
        close_out();
    end
endmodule
